// ==== rtl/port_power_ctl.sv ====
// Per-port power state, steered by global power commands and the mask.
// Assumes one-cycle command strobes from the status register block.
`timescale 1ns/1ps
`default_nettype none
module port_power_ctl #(
    parameter int NUM_PORTS = 2
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Mode and mask
    input wire logic per_port_mode_i,
    input wire logic [NUM_PORTS-1:0] port_power_mask_i,
    // Global commands
    input wire logic power_on_i,
    input wire logic power_off_i,
    // Per-port commands for masked ports
    input wire logic [NUM_PORTS-1:0] port_set_i,
    input wire logic [NUM_PORTS-1:0] port_clear_i,
    // Port power state
    output logic [NUM_PORTS-1:0] port_power_o
);

    // Next power state of every port
    wire logic [NUM_PORTS-1:0] next_power;

    // Each port follows global or per-port commands
    genvar g;
    generate
        for (g = 0; g < NUM_PORTS; g++) begin : g_port
            wire logic follows_global;
            wire logic on_cmd;
            wire logic off_cmd;
            assign follows_global = !per_port_mode_i
                || !port_power_mask_i[g];
            assign on_cmd = follows_global ? power_on_i
                : port_set_i[g];
            assign off_cmd = follows_global ? power_off_i
                : port_clear_i[g];
            // On wins when both arrive together
            assign next_power[g] = on_cmd ? 1'b1
                : (off_cmd ? 1'b0 : port_power_o[g]);
        end
    endgenerate

    // Power flops, one process for the whole vector
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            port_power_o <= '0;
        end else begin
            port_power_o <= next_power;
        end
    end

    // Masked port ignores a global on in per-port mode
    a_mask_holds: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        (per_port_mode_i && port_power_mask_i[0] && power_on_i
         && !port_set_i[0] && !port_clear_i[0])
        |=> $stable(port_power_o[0]))
        else $error("masked port changed on global command");
    // Global mode on command powers every port
    a_global_on: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        (!per_port_mode_i && power_on_i) |=> (&port_power_o))
        else $error("global power on missed a port");
    // Global off command in global mode clears all
    a_global_off: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        (!per_port_mode_i && power_off_i && !power_on_i)
        |=> (port_power_o == '0))
        else $error("global power off missed a port");

endmodule
`default_nettype wire

// ==== rtl/rh_status_pkg.sv ====
// Package: offsets, field positions, reset values and types of the
// root hub status register block.
// Assumes a 32-bit register access port with a byte address.
package rh_status_pkg;

    // Register placement
    localparam logic [11:0] ROOT_HUB_STATUS_OFFSET = 12'h050;

    // Field positions
    localparam int WAKE_ENABLE_CLEAR_BIT = 31;
    localparam int OVERCURRENT_CHANGE_BIT = 17;
    localparam int GLOBAL_POWER_ON_BIT = 16;
    localparam int REMOTE_WAKE_ENABLE_BIT = 15;
    localparam int OVERCURRENT_IND_BIT = 1;
    localparam int GLOBAL_POWER_OFF_BIT = 0;

    // Values after reset
    localparam logic RESET_WAKE_ENABLE = 1'b0;
    localparam logic RESET_OC_CHANGE = 1'b0;
    localparam logic RESET_OC_IND = 1'b0;
    localparam logic [31:0] RESET_READ_DATA = 32'h0000_0000;

    // Bus request carried as one bundle
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

    // Decoded command strobes of one write
    typedef struct packed {
        logic wake_clear;
        logic oc_change_clear;
        logic power_on;
        logic wake_set;
        logic power_off;
    } status_cmd_t;

    // Wake sequencer states
    typedef enum logic [1:0] {
        WAKE_IDLE = 2'b01,
        WAKE_RESUMING = 2'b10
    } wake_state_t;

endpackage

// ==== rtl/root_hub_status_register.sv ====
// Root hub status register: hub-wide status bits and power/wake commands.
// Assumes a single-cycle register port from the bus front end and a
// synchronous overcurrent level from the port hardware.
//
// Summary of operation
// - The register answers at offset 0x50 from the memory base.
// - A 1 written to bit 31 clears remote wakeup enable; 0 does nothing.
// - Hardware sets bit 17 whenever the overcurrent indicator changes.
// - Writing 1 to bit 17 clears the change flag; writing 0 does nothing.
// - Bit 16 always reads as zero.
// - In global mode a 1 written to bit 16 powers all ports on.
// - In per-port mode a 1 to bit 16 powers on only unmasked ports.
// - With wake enabled, a connect change while suspended starts resume.
// - A 1 written to bit 15 sets remote wakeup enable; 0 does nothing.
// - With global reporting bit 1 reads 1 during overcurrent.
// - With per-port overcurrent protection bit 1 always reads 0.
// - Bit 0 always reads as zero.
// - In global mode a 1 written to bit 0 powers all ports off.
// - In per-port mode a 1 to bit 0 powers off only unmasked ports.
// - In per-port mode a set mask bit gives its port to per-port commands only.
`timescale 1ns/1ps
`default_nettype none
module root_hub_status_register #(
    parameter int NUM_PORTS = 2
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Register access port
    input wire rh_status_pkg::reg_req_t req_i,
    output logic [31:0] rdata_o,
    output logic rvalid_o,
    // Configuration from the descriptor registers
    input wire logic per_port_mode_i,
    input wire logic per_port_overcurrent_i,
    input wire logic [NUM_PORTS-1:0] port_power_mask_i,
    // Per-port power commands from the port registers
    input wire logic [NUM_PORTS-1:0] port_set_i,
    input wire logic [NUM_PORTS-1:0] port_clear_i,
    // Hub events
    input wire logic overcurrent_i,
    input wire logic connect_change_flag_i,
    input wire logic host_suspended_state_i,
    // Control outputs
    output logic [NUM_PORTS-1:0] port_power_o,
    output logic resume_start_o,
    output logic resume_detected_o,
    output logic remote_wake_enable_o
);

    // Register state
    logic remote_wake_enable;
    logic overcurrent_change_flag;
    logic overcurrent_indicator;
    rh_status_pkg::wake_state_t wake_state;
    rh_status_pkg::wake_state_t next_wake_state;

    // Address decode of the single register
    wire logic hit;
    wire logic wr_hit;
    wire logic rd_hit;
    assign hit = (req_i.addr == rh_status_pkg::ROOT_HUB_STATUS_OFFSET);
    assign wr_hit = req_i.wr && hit;
    assign rd_hit = req_i.rd && hit;

    // Write command decode
    function automatic rh_status_pkg::status_cmd_t decode_cmd(
        input logic en,
        input logic [31:0] d
    );
        rh_status_pkg::status_cmd_t c;
        c.wake_clear = en && d[rh_status_pkg::WAKE_ENABLE_CLEAR_BIT];
        c.oc_change_clear = en && d[rh_status_pkg::OVERCURRENT_CHANGE_BIT];
        c.power_on = en && d[rh_status_pkg::GLOBAL_POWER_ON_BIT];
        c.wake_set = en && d[rh_status_pkg::REMOTE_WAKE_ENABLE_BIT];
        c.power_off = en && d[rh_status_pkg::GLOBAL_POWER_OFF_BIT];
        return c;
    endfunction

    // Reserved write bits are ignored; software writes them as zero
    wire rh_status_pkg::status_cmd_t cmd;
    assign cmd = decode_cmd(wr_hit, req_i.wdata);

    // Overcurrent indicator as reported, forced low under per-port overcurrent protection
    wire logic next_oc_ind;
    wire logic oc_changed;
    assign next_oc_ind = overcurrent_i && !per_port_overcurrent_i;
    assign oc_changed = (next_oc_ind != overcurrent_indicator);

    // Wake enable next value: clear command takes precedence over set
    wire logic next_wake_enable;
    assign next_wake_enable = cmd.wake_clear ? 1'b0
        : (cmd.wake_set ? 1'b1 : remote_wake_enable);

    // Change flag next value: a change wins over a clear
    wire logic next_oc_change;
    assign next_oc_change = oc_changed ? 1'b1
        : (cmd.oc_change_clear ? 1'b0 : overcurrent_change_flag);

    // Resume event from a connect change while suspended
    wire logic resume_event;
    assign resume_event = remote_wake_enable && connect_change_flag_i
        && host_suspended_state_i;

    // Read data assembly; local power bits read as zero
    wire logic [31:0] read_word;
    assign read_word = {
        14'h0000,
        overcurrent_change_flag,
        1'b0,
        remote_wake_enable,
        13'h0000,
        overcurrent_indicator,
        1'b0
    };

    // Status flops
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            remote_wake_enable <= rh_status_pkg::RESET_WAKE_ENABLE;
            overcurrent_change_flag <= rh_status_pkg::RESET_OC_CHANGE;
            overcurrent_indicator <= rh_status_pkg::RESET_OC_IND;
        end else begin
            remote_wake_enable <= next_wake_enable;
            overcurrent_change_flag <= next_oc_change;
            overcurrent_indicator <= next_oc_ind;
        end
    end

    // Wake sequencer: idle until a resume event, then one resume pulse
    always_comb begin
        next_wake_state = wake_state;
        case (wake_state)
            rh_status_pkg::WAKE_IDLE: begin
                if (resume_event) begin
                    next_wake_state = rh_status_pkg::WAKE_RESUMING;
                end
            end
            rh_status_pkg::WAKE_RESUMING: begin
                if (!host_suspended_state_i) begin
                    next_wake_state = rh_status_pkg::WAKE_IDLE;
                end
            end
            default: begin
                next_wake_state = rh_status_pkg::WAKE_IDLE;
            end
        endcase
    end

    // Sequencer state and its registered outputs
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            wake_state <= rh_status_pkg::WAKE_IDLE;
            resume_start_o <= 1'b0;
            resume_detected_o <= 1'b0;
        end else begin
            wake_state <= next_wake_state;
            resume_start_o <= (wake_state == rh_status_pkg::WAKE_IDLE)
                && resume_event;
            resume_detected_o <= (wake_state == rh_status_pkg::WAKE_IDLE)
                && resume_event;
        end
    end

    // Read port and wake enable mirror
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rdata_o <= rh_status_pkg::RESET_READ_DATA;
            rvalid_o <= 1'b0;
            remote_wake_enable_o <= 1'b0;
        end else begin
            rdata_o <= rd_hit ? read_word : 32'h0000_0000;
            rvalid_o <= req_i.rd;
            remote_wake_enable_o <= next_wake_enable;
        end
    end

    // Port power switching behind the global commands
    port_power_ctl #(
        .NUM_PORTS(NUM_PORTS)
    ) u_power (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .per_port_mode_i(per_port_mode_i),
        .port_power_mask_i(port_power_mask_i),
        .power_on_i(cmd.power_on),
        .power_off_i(cmd.power_off),
        .port_set_i(port_set_i),
        .port_clear_i(port_clear_i),
        .port_power_o(port_power_o)
    );

    // Clear command drops wake enable on the next edge
    a_wake_clear: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        cmd.wake_clear |=> !remote_wake_enable)
        else $error("wake enable survived clear");
    // Set alone raises wake enable
    a_wake_set: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        (cmd.wake_set && !cmd.wake_clear) |=> remote_wake_enable)
        else $error("wake enable not set");
    // Writes without wake commands leave wake enable alone
    a_wake_hold: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        (!cmd.wake_set && !cmd.wake_clear) |=> $stable(remote_wake_enable))
        else $error("wake enable moved without command");
    // Mirror output always equals the wake enable bit
    a_wake_mirror: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        remote_wake_enable_o == remote_wake_enable)
        else $error("wake enable output differs from bit");
    // Any indicator change raises the change flag
    a_oc_change: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        !$stable(overcurrent_indicator) |-> overcurrent_change_flag)
        else $error("overcurrent change not flagged");
    // Clear with no change drops the flag
    a_oc_clear: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        (cmd.oc_change_clear && !oc_changed) |=> !overcurrent_change_flag)
        else $error("change flag survived clear");
    // Flag holds without a clear
    a_oc_hold: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        (overcurrent_change_flag && !cmd.oc_change_clear)
        |=> overcurrent_change_flag)
        else $error("change flag lost");
    // Flag holds when neither a change nor a clear arrives
    a_flag_idle: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        (!oc_changed && !cmd.oc_change_clear)
        |=> $stable(overcurrent_change_flag))
        else $error("change flag moved on its own");
    // Local power bits never read as one
    a_lp_zero: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        rvalid_o |-> (rdata_o[16] == 1'b0 && rdata_o[0] == 1'b0))
        else $error("local power bit read as one");
    // Every read strobe is answered on the next edge
    a_read_valid: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        req_i.rd |=> rvalid_o)
        else $error("read strobe not answered");
    // Reads of other offsets return zero
    a_miss_zero: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        (req_i.rd && !hit) |=> (rdata_o == 32'h0000_0000))
        else $error("read of other offset returned data");
    // Write to another offset leaves wake enable alone
    a_miss_write: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        (req_i.wr && !hit) |=> $stable(remote_wake_enable))
        else $error("write to other offset took effect");
    // Read word carries the state bits and zero elsewhere
    a_read_word: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        rd_hit |=> (rdata_o == {14'h0000, $past(overcurrent_change_flag),
            1'b0, $past(remote_wake_enable), 13'h0000,
            $past(overcurrent_indicator), 1'b0}))
        else $error("read word does not match state");
    // Indicator tracks overcurrent one cycle on in global reporting
    a_oc_track: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        (overcurrent_i && !per_port_overcurrent_i) ##1
        (overcurrent_i && !per_port_overcurrent_i) |-> overcurrent_indicator)
        else $error("indicator missed overcurrent");
    // Normal power operation clears the indicator
    a_ind_normal: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        !overcurrent_i |=> !overcurrent_indicator)
        else $error("indicator set without overcurrent");
    // Per-port protection keeps the indicator low
    a_oc_perport: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        per_port_overcurrent_i |=> !overcurrent_indicator)
        else $error("indicator set under per-port protection");
    // Ports keep their power without any command
    a_power_idle: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        (!cmd.power_on && !cmd.power_off && port_set_i == '0
         && port_clear_i == '0) |=> $stable(port_power_o))
        else $error("port power moved without command");
    // Resume event while idle raises both pulses
    a_resume: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        (resume_event && wake_state == rh_status_pkg::WAKE_IDLE)
        |=> (resume_start_o && resume_detected_o
             && wake_state == rh_status_pkg::WAKE_RESUMING))
        else $error("resume event not taken");
    // A resume pulse lasts one cycle only
    a_one_pulse: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        resume_start_o |=> !resume_start_o)
        else $error("resume pulse longer than a cycle");
    // Resuming state is kept while the host stays suspended
    a_resume_hold: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        (wake_state == rh_status_pkg::WAKE_RESUMING
         && host_suspended_state_i)
        |=> (wake_state == rh_status_pkg::WAKE_RESUMING && !resume_start_o))
        else $error("resume sequencer left too early");
    // Wake disabled means no resume
    a_no_wake: assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
        !remote_wake_enable |=> !resume_start_o)
        else $error("resume without wake enable");
    // Reset leaves wake enable, change flag and read data at zero
    a_reset_zero: assert property (
        @(posedge sys_clk_i)
        $past(reset_i) |-> (!remote_wake_enable && !overcurrent_change_flag
                            && rdata_o == 32'h0000_0000))
        else $error("state not zero after reset");

endmodule
`default_nettype wire

// ==== tb/host_driver_model.sv ====
// Host driver model: issues single register writes and reads.
// Assumes the one-cycle strobe port with a registered read answer.
`timescale 1ns/1ps
`default_nettype none
module host_driver_model (
    // Clock
    input wire logic sys_clk_i,
    // Register port
    output var rh_status_pkg::reg_req_t req_o,
    input wire logic [31:0] rdata_i,
    input wire logic rvalid_i
);
    // Only implemented bits may carry a one
    localparam logic [31:0] IMPL_MASK = 32'h8003_8001;

    initial req_o = '0;

    // One write strobe, reserved bits written as zero
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk_i) #1;
        req_o = '{1'b1, 1'b0, a, d & IMPL_MASK};
        @(posedge sys_clk_i) #1;
        req_o = '0;
    endtask

    // One read strobe, answer taken the cycle after
    task automatic rd(input logic [11:0] a, output logic [31:0] d,
                      output logic v);
        @(posedge sys_clk_i) #1;
        req_o = '{1'b0, 1'b1, a, 32'h0000_0000};
        @(posedge sys_clk_i) #1;
        req_o = '0;
        d = rdata_i;
        v = rvalid_i;
    endtask
endmodule
`default_nettype wire

// ==== tb/root_hub_status_register_tb_top.sv ====
// Testbench: random and corner writes, overcurrent and resume checks.
// Assumes the host driver model as bus master and two ports.
`timescale 1ns/1ps
`default_nettype none
module root_hub_status_register_tb_top;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    rh_status_pkg::reg_req_t req;
    logic [31:0] rdata, word, seed = 32'h0000_3078;
    logic rvalid, v, ppm = 1'b0, ppoc = 1'b0, oc = 1'b0;
    logic conn = 1'b0, susp = 1'b0, rstart, rdet, wake_o;
    logic [1:0] mask = 2'h0, pset = 2'h0, pclr = 2'h0, ppow, pow_m = 2'h0;
    logic wake_m = 1'b0, oci_m = 1'b0, occ_m = 1'b0;
    logic [7:0] cs, cd;
    int errors = 0, total_checks = 0, cycles = 0;

    // Clock and timeout
    always #4 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            results();
        end
    end

    root_hub_status_register #(.NUM_PORTS(2)) u_dut (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .req_i(req),
        .rdata_o(rdata), .rvalid_o(rvalid), .per_port_mode_i(ppm),
        .per_port_overcurrent_i(ppoc), .port_power_mask_i(mask),
        .port_set_i(pset), .port_clear_i(pclr), .overcurrent_i(oc),
        .connect_change_flag_i(conn), .host_suspended_state_i(susp),
        .port_power_o(ppow), .resume_start_o(rstart),
        .resume_detected_o(rdet), .remote_wake_enable_o(wake_o));

    host_driver_model u_host (
        .sys_clk_i(sys_clk_i), .req_o(req), .rdata_i(rdata),
        .rvalid_i(rvalid));

    // Xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected read word from the shadow state
    function automatic logic [31:0] exp_word();
        return {14'h0, occ_m, 1'b0, wake_m, 13'h0, oci_m, 1'b0};
    endfunction

    // Expected port power after a global command write
    function automatic logic [1:0] next_pow(input logic [31:0] d);
        logic [1:0] p;
        p = pow_m;
        for (int i = 0; i < 2; i++) begin
            if (!ppm || !mask[i]) begin
                if (d[16]) p[i] = 1'b1;
                else if (d[0]) p[i] = 1'b0;
            end
        end
        return p;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    // Read back the register, the port power and the wake enable output
    task automatic readchk();
        u_host.rd(12'h050, word, v);
        check({31'h0, v}, 32'h1);
        check(word, exp_word());
        check({30'h0, ppow}, {30'h0, pow_m});
        check({31'h0, wake_o}, {31'h0, wake_m});
    endtask

    task automatic results();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        tick(5);
        reset_i = 1'b0;
        readchk();
        u_host.rd(12'h054, word, v);
        check({31'h0, v}, 32'h1);
        check(word, 32'h0000_0000);
        for (int n = 0; n < 40; n++) begin
            word = rnd();
            ppm = word[5];
            mask = word[7:6];
            if (n == 0) word = 32'hffff_ffff;
            pow_m = next_pow(word);
            if (word[31]) wake_m = 1'b0;
            else if (word[15]) wake_m = 1'b1;
            if (word[17]) occ_m = 1'b0;
            u_host.wr(12'h050, word);
            pset = word[9:8];
            pclr = ~word[9:8] & word[11:10];
            for (int i = 0; i < 2; i++) begin
                if (ppm && mask[i] && pset[i]) pow_m[i] = 1'b1;
                else if (ppm && mask[i] && pclr[i]) pow_m[i] = 1'b0;
            end
            tick(1);
            pset = 2'h0;
            pclr = 2'h0;
            u_host.wr(12'h054, rnd());
            readchk();
        end
        // Overcurrent indicator and change flag
        oc = 1'b1;
        oci_m = 1'b1;
        occ_m = 1'b1;
        tick(3);
        readchk();
        u_host.wr(12'h050, 32'h0002_0000);
        occ_m = 1'b0;
        readchk();
        oc = 1'b0;
        oci_m = 1'b0;
        occ_m = 1'b1;
        tick(3);
        readchk();
        ppoc = 1'b1;
        oc = 1'b1;
        tick(3);
        readchk();
        // Resume with wake disabled, then enabled
        for (int k = 0; k < 2; k++) begin
            u_host.wr(12'h050, k ? 32'h0000_8000 : 32'h8000_0000);
            wake_m = k[0];
            susp = 1'b1;
            conn = 1'b1;
            cs = 8'h00;
            cd = 8'h00;
            repeat (6) begin
                tick(1);
                cs = cs + {7'h0, rstart};
                cd = cd + {7'h0, rdet};
            end
            susp = 1'b0;
            conn = 1'b0;
            check({24'h0, cs}, k);
            check({24'h0, cd}, k);
            readchk();
        end
        // Reset in mid-run with wake and change flag set
        reset_i = 1'b1;
        tick(2);
        reset_i = 1'b0;
        wake_m = 1'b0;
        occ_m = 1'b0;
        pow_m = 2'h0;
        readchk();
        results();
    end
endmodule
`default_nettype wire
